//--- rtl/dcc_counter.v
`timescale 1ns/10ps
`include "dcc_regs.vh"
module dcc_counter #(
  parameter N = 6,
  parameter [7:0] POINT_CYC = `DCC_POINT_CYC,
  parameter [7:0] CARRY_CYC = `DCC_CARRY_CYC
) (
  // clock and reset
  input wire i_clk,
  input wire i_nrst,
  // wishbone slave
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  // card and control pins
  input wire [N-1:0] i_start,
  input wire [N-1:0] i_stop,
  input wire i_sub_ctrl,
  input wire i_carry_input_hub,
  // carry, listing and cycle point outputs
  output reg o_carry_out,
  output reg [N-1:0] o_list,
  output reg [3:0] o_point,
  output reg o_carry_time
);
  // ============================================================
  // sequencer states
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_ADD = 2'h1;
  localparam [1:0] ST_CARRY = 2'h2;

  reg [1:0] state;
  reg [7:0] cnt;
  reg [1:0] ctrl;
  reg [N-1:0] running;
  wire [N-1:0] start_s;
  wire [N-1:0] stop_s;
  wire sub_s;
  wire cin_s;
  wire [4*N-1:0] digits;
  wire [N-1:0] pend;
  reg [N-1:0] step;
  reg [N-1:0] active;
  reg [N:0] cin;
  reg [N-1:0] load;
  reg [31:0] value_rd;
  reg [31:0] value_wr;
  wire tick;
  wire carry_end;
  wire wb_req;
  reg hit_ctrl;
  reg hit_status;
  reg hit_value;
  reg [31:0] status_word;
  integer i;
  integer j;

  // byte-lane merge for register writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        merge[8*k +: 8] = sel[k] ? nw[8*k +: 8] : old[8*k +: 8];
      end
    end
  endfunction

  // ============================================================
  // pin synchronisers; impulses stand a whole point, so the
  // two-cycle delay only shortens the sampling margin
  dcc_sync #(.W(2*N + 2)) u_sync (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_d({i_start, i_stop, i_sub_ctrl, i_carry_input_hub}),
    .o_q({start_s, stop_s, sub_s, cin_s})
  );

  // ============================================================
  // machine cycle: points 9 down to 0, then the carry window
  // the points run whether or not a wheel started, so the carry
  // window always follows point 0 and a missing stop never hangs
  assign tick = (state == ST_ADD) && (cnt == POINT_CYC - 8'h1);
  assign carry_end = (state == ST_CARRY) && (cnt == CARRY_CYC - 8'h1);

  always @(posedge i_clk) begin
    if (!i_nrst) begin
      state <= ST_IDLE;
      cnt <= 8'h0;
      o_point <= `DCC_POINT_FIRST;
    end else begin
      case (state)
        ST_IDLE: begin
          cnt <= 8'h0;
          o_point <= `DCC_POINT_FIRST;
          if (ctrl[`DCC_CTRL_RUN_BIT]) begin
            state <= ST_ADD;
          end
        end
        ST_ADD: begin
          if (tick) begin
            cnt <= 8'h0;
            if (o_point == `DCC_POINT_LAST) begin
              state <= ST_CARRY;
            end else begin
              o_point <= o_point - 4'h1;
            end
          end else begin
            cnt <= cnt + 8'h1;
          end
        end
        ST_CARRY: begin
          if (carry_end) begin
            cnt <= 8'h0;
            o_point <= `DCC_POINT_FIRST;
            state <= ctrl[`DCC_CTRL_RUN_BIT] ? ST_ADD : ST_IDLE;
          end else begin
            cnt <= cnt + 8'h1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ============================================================
  // start and stop of wheels during the add period
  always @* begin
    for (i = 0; i < N; i = i + 1) begin
      // subtract: hot nine starts all wheels at point 9
      if (sub_s) begin
        active[i] = (running[i] || o_point == `DCC_POINT_FIRST)
          && !stop_s[i];
      end else begin
        active[i] = (running[i] || start_s[i]);
      end
      // point 0 closes the add period, so at most nine steps
      if (o_point == `DCC_POINT_LAST) begin
        active[i] = 1'b0;
      end
      step[i] = tick && active[i];
    end
  end

  // running wheels; an unstopped one runs until point 0
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      running <= {N{1'b0}};
    end else if (state != ST_ADD) begin
      running <= {N{1'b0}};
    end else if (tick) begin
      running <= active;
    end
  end

  // ============================================================
  // carry ripple: nines relay, latched wraps originate; the
  // end-around term uses the registered carry out so there is
  // no combinational loop through the group
  // a nine stepped by carry wraps to zero but latches nothing,
  // so the carry it relays is never counted twice
  always @* begin
    cin[0] = cin_s
      || (ctrl[`DCC_CTRL_LOOP_BIT] && sub_s && o_carry_out);
    for (j = 0; j < N; j = j + 1) begin
      cin[j+1] = pend[j]
        || (digits[4*j +: 4] == `DCC_DIGIT_NINE && cin[j]);
    end
  end

  // carry out stands through the carry window for the next group
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      o_carry_out <= 1'b0;
      o_carry_time <= 1'b0;
    end else begin
      o_carry_out <= (state == ST_CARRY) && !carry_end && cin[N];
      o_carry_time <= (state == ST_CARRY) && !carry_end;
    end
  end

  // ============================================================
  // listing: in subtract the sensed impulse passes to print
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      o_list <= {N{1'b0}};
    end else begin
      o_list <= (sub_s && state == ST_ADD) ? stop_s : {N{1'b0}};
    end
  end

  // ============================================================
  // digit positions
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_pos
      dcc_digit u_digit (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_load(load[g]),
        .i_load_val(value_wr[4*g +: 4]),
        .i_step(step[g]),
        .i_carry(carry_end && cin[g]),
        .i_clr_pend(carry_end),
        .o_digit(digits[4*g +: 4]),
        .o_pend(pend[g])
      );
    end
  endgenerate

  // ============================================================
  // register access; value preload only while idle, since a
  // load mid-cycle would corrupt latched carries
  assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;

  // address decode; unmapped places read zero and drop writes,
  // but are still acknowledged so a stray access cannot hang
  always @* begin
    hit_ctrl = 1'b0;
    hit_status = 1'b0;
    hit_value = 1'b0;
    if (i_wb_adr == `DCC_CTRL_OFS) begin
      hit_ctrl = 1'b1;
    end else if (i_wb_adr == `DCC_STATUS_OFS) begin
      hit_status = 1'b1;
    end else if (i_wb_adr == `DCC_VALUE_OFS) begin
      hit_value = 1'b1;
    end
  end

  // status word; pending latches show only between the add
  // period and the end of the carry window
  always @* begin
    status_word = 32'h0;
    status_word[N-1:0] = pend;
    status_word[`DCC_STAT_POINT_LSB +: 4] = o_point;
    status_word[`DCC_STAT_CARRY_BIT] = o_carry_time;
    status_word[`DCC_STAT_SUB_BIT] = sub_s;
    status_word[`DCC_STAT_COUT_BIT] = o_carry_out;
  end

  // preload merges byte lanes over the current wheels, so a
  // partial write keeps the untouched digits
  always @* begin
    value_rd = 32'h0;
    value_rd[4*N-1:0] = digits;
    value_wr = merge(value_rd, i_wb_dat, i_wb_sel);
    load = {N{1'b0}};
    if (wb_req && i_wb_we && hit_value && state == ST_IDLE) begin
      load = {N{1'b1}};
    end
  end

  // classic single-cycle ack, dropped in the following cycle;
  // a write lands at the edge that raises ack
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0;
      ctrl <= `DCC_CTRL_RST;
    end else begin
      o_wb_ack <= wb_req;
      if (wb_req && i_wb_we && hit_ctrl && i_wb_sel[0]) begin
        ctrl <= i_wb_dat[1:0];
      end
      if (wb_req && !i_wb_we) begin
        if (hit_ctrl) begin
          o_wb_dat <= {30'h0, ctrl};
        end else if (hit_status) begin
          o_wb_dat <= status_word;
        end else if (hit_value) begin
          o_wb_dat <= value_rd;
        end else begin
          o_wb_dat <= 32'h0;
        end
      end
    end
  end
endmodule

//--- rtl/dcc_regs.vh
`ifndef DCC_REGS_VH
`define DCC_REGS_VH

// ============================================================
// register offsets (byte addresses, one word each)
`define DCC_CTRL_OFS 8'h00
`define DCC_STATUS_OFS 8'h04
`define DCC_VALUE_OFS 8'h08

// ============================================================
// control fields and reset value
`define DCC_CTRL_RUN_BIT 0
`define DCC_CTRL_LOOP_BIT 1
`define DCC_CTRL_RST 2'h0

// ============================================================
// status fields
`define DCC_STAT_POINT_LSB 8
`define DCC_STAT_CARRY_BIT 12
`define DCC_STAT_SUB_BIT 13
`define DCC_STAT_COUT_BIT 14

// ============================================================
// digit values and cycle points
`define DCC_DIGIT_NINE 4'h9
`define DCC_DIGIT_ZERO 4'h0
`define DCC_POINT_FIRST 4'h9
`define DCC_POINT_LAST 4'h0

// ============================================================
// timing: clock period, cycle point and carry window in ns
`define DCC_CLK_NS 10
`define DCC_POINT_NS 100
`define DCC_CARRY_NS 80
`define DCC_POINT_CYC ((`DCC_POINT_NS + `DCC_CLK_NS - 1) / `DCC_CLK_NS)
`define DCC_CARRY_CYC (`DCC_CARRY_NS / `DCC_CLK_NS)

`endif

//--- rtl/dcc_sync.v
`timescale 1ns/10ps
// ============================================================
// two flip-flop synchroniser for pin levels
module dcc_sync #(
  parameter W = 1
) (
  // clock and reset
  input wire i_clk,
  input wire i_nrst,
  // levels
  input wire [W-1:0] i_d,
  output reg [W-1:0] o_q
);
  reg [W-1:0] meta;

  // first stage feeds only the second stage
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      meta <= {W{1'b0}};
      o_q <= {W{1'b0}};
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule

//--- rtl/dcc_digit.v
`timescale 1ns/10ps
`include "dcc_regs.vh"
// ============================================================
// one decimal wheel with its carry-pending latch
module dcc_digit (
  // clock and reset
  input wire i_clk,
  input wire i_nrst,
  // software preload
  input wire i_load,
  input wire [3:0] i_load_val,
  // stepping
  input wire i_step,
  input wire i_carry,
  input wire i_clr_pend,
  // state
  output reg [3:0] o_digit,
  output reg o_pend
);
  // modulo ten increment
  function [3:0] next_digit;
    input [3:0] d;
    begin
      if (d == `DCC_DIGIT_NINE) begin
        next_digit = `DCC_DIGIT_ZERO;
      end else begin
        next_digit = d + 4'h1;
      end
    end
  endfunction

  // wheel and latch; a wrap in carry time never latches
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      o_digit <= `DCC_DIGIT_ZERO;
      o_pend <= 1'b0;
    end else if (i_load) begin
      o_digit <= (i_load_val > `DCC_DIGIT_NINE) ? `DCC_DIGIT_ZERO : i_load_val;
      o_pend <= 1'b0;
    end else begin
      if (i_step || i_carry) begin
        o_digit <= next_digit(o_digit);
      end
      if (i_step && o_digit == `DCC_DIGIT_NINE) begin
        o_pend <= 1'b1;
      end else if (i_clr_pend) begin
        o_pend <= 1'b0;
      end
    end
  end
endmodule

//--- dv/dcc_counter_assertions.sv
`timescale 1ns/10ps
// ============================================================
// port checker for the decimal counter group
module dcc_counter_chk #(
  parameter N = 6
) (
  // clock and reset
  input wire i_clk,
  input wire i_nrst,
  // bus and pins
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire o_wb_ack,
  input wire [N-1:0] i_stop,
  input wire i_sub_ctrl,
  input wire o_carry_out,
  input wire [N-1:0] o_list,
  input wire [3:0] o_point,
  input wire o_carry_time
);
  default clocking chk_cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  // ============================================================
  // bus handshake
  ack_single_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");
  ack_answer_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("request not acknowledged next cycle");

  // ============================================================
  // cycle points: nine down to zero, points eight to one each held at least nine clocks
  point_range_a: assert property (o_point <= 4'h9)
    else $error("cycle point out of range");
  point_step_a: assert property ($changed(o_point) && o_point != 4'h9 |->
    o_point == $past(o_point) - 4'h1) else $error("cycle point skipped");
  point_hold_a: assert property ($changed(o_point) && o_point != 4'h9 && o_point != 4'h0
    |=> $stable(o_point) [*8]) else $error("cycle point too short");

  // ============================================================
  // carry window and carry exit
  carry_window_len_a: assert property ($rose(o_carry_time) |->
    o_carry_time [*7] ##1 !o_carry_time) else $error("carry window length wrong");
  carry_exit_time_a: assert property (o_carry_out |-> o_carry_time ||
    $past(o_carry_time) || $past(o_carry_time, 2)) else $error("carry exit outside window");

  // ============================================================
  // listing only mirrors sensed stops while subtracting
  list_stop_a: assert property ((o_list & ~$past(i_stop, 3)) == '0)
    else $error("listing without sensed digit");
  list_sub_a: assert property (|o_list |-> $past(i_sub_ctrl, 3))
    else $error("listing outside subtract");

  cover property (o_wb_ack);
  cover property (o_carry_out);
  cover property (|o_list);
endmodule

bind dcc_counter dcc_counter_chk #(.N(N)) dcc_counter_chk_inst (.i_clk(i_clk),
  .i_nrst(i_nrst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack),
  .i_stop(i_stop), .i_sub_ctrl(i_sub_ctrl), .o_carry_out(o_carry_out), .o_list(o_list),
  .o_point(o_point), .o_carry_time(o_carry_time));

//--- dv/dcc_card_model.sv
`timescale 1ns/10ps
// ============================================================
// card brushes and program control seen from the counter
module dcc_card_model #(
  parameter N = 6
) (
  // clock and cycle timing from the counter
  input wire i_clk,
  input wire [3:0] i_point,
  input wire i_carry_time,
  // card digits and mode from the bench
  input wire i_sub,
  input wire [4*N-1:0] i_card,
  // impulses towards the counter
  output reg [N-1:0] o_start = '0,
  output reg [N-1:0] o_stop = '0,
  output reg o_sub_ctrl = 1'b0
);
  integer g;

  // levels change just after an edge; no impulses during carry time
  always @(posedge i_clk) begin
    // one program level drives this group; a coupled group takes the same one
    o_sub_ctrl <= i_sub; // held as long as the bench holds the mode
    for (g = 0; g < N; g = g + 1) begin
      o_start[g] <= !i_sub && i_card[4*g+:4] != 4'h0 && i_point <= i_card[4*g+:4]
        && !i_carry_time;
      o_stop[g] <= i_sub && i_point == i_card[4*g+:4] && !i_carry_time;
    end
  end
endmodule

//--- dv/dcc_counter_bench.sv
`timescale 1ns/10ps
// ============================================================
// self-checking bench: six positions, one card cycle per test
module dcc_counter_bench;
  reg i_clk = 1'b0;
  reg i_nrst = 1'b0;
  reg cyc = 1'b0, stb = 1'b0, we = 1'b0, sub = 1'b0, hub = 1'b0, hub_en = 1'b0;
  reg co_seen = 1'b0, list_seen = 1'b0;
  reg [3:0] sel = 4'hf;
  reg [7:0] adr = 8'h00;
  reg [31:0] wdat = 32'h0, q;
  reg [23:0] card = 24'h0;
  wire [31:0] rdat;
  wire ack, cout, ctime, subc;
  wire [5:0] start, stop, list;
  wire [3:0] point;
  integer fail_count = 0, n_tests = 0;

  dcc_counter dcc_counter_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_start(start), .i_stop(stop), .i_sub_ctrl(subc),
    .i_carry_input_hub(hub), .o_carry_out(cout), .o_list(list), .o_point(point),
    .o_carry_time(ctime));
  dcc_card_model dcc_card_model_inst (.i_clk(i_clk), .i_point(point), .i_carry_time(ctime),
    .i_sub(sub), .i_card(card), .o_start(start), .o_stop(stop), .o_sub_ctrl(subc));

  initial forever #5 i_clk = ~i_clk;

  // optional external loop from carry exit to carry entry, plus event flags
  always @(posedge i_clk) begin
    hub <= hub_en & cout; // end-around through the pins
    if (cout === 1'b1) co_seen <= 1'b1;
    if (|list) list_seen <= 1'b1;
  end

  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask

  task results;
    begin
      $display("compares %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask

  // one classic cycle; q holds read data taken at the ack edge
  task wb(input [7:0] a, input w, input [31:0] d);
    integer k;
    begin
      @(posedge i_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      k = 0;
      @(posedge i_clk);
      while (ack !== 1'b1 && k < 20) begin
        @(posedge i_clk);
        k = k + 1;
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (k >= 20) begin
        chk(32'h1, 32'h0);
        results;
      end
    end
  endtask

  // preload, run one card cycle, stop in carry time, read back the wheels
  task scen(input [23:0] pre, input [23:0] c, input s, input lp, input he, input [23:0] exp);
    integer k;
    begin
      card <= c;
      sub <= s;
      hub_en <= he;
      co_seen = 1'b0;
      list_seen = 1'b0;
      wb(8'h08, 1'b1, {8'h00, pre});
      wb(8'h00, 1'b1, {30'h0, lp, 1'b1});
      k = 0;
      while (ctime !== 1'b1 && k < 400) begin
        @(posedge i_clk);
        k = k + 1;
      end
      if (k >= 400) begin
        chk(32'h1, 32'h0);
        results;
      end
      wb(8'h00, 1'b1, {30'h0, lp, 1'b0});
      repeat (30) @(posedge i_clk);
      wb(8'h08, 1'b0, 32'h0);
      chk(q, {8'h00, exp});
      $display("test done: %h with card %h gives %h", pre, c, q[23:0]);
    end
  endtask

  initial begin
    repeat (20) @(posedge i_clk);
    i_nrst <= 1'b1;
    wb(8'h00, 1'b0, 32'h0);
    chk(q, 32'h0); // control register clears on reset
    wb(8'h0c, 1'b0, 32'h0);
    chk(q, 32'h0); // unmapped place reads zero
    wb(8'h04, 1'b0, 32'h0);
    chk(q, 32'h00000900); // idle status rests at cycle point nine
    $display("test done: reset values");
    scen(24'h000268, 24'h000533, 1'b0, 1'b0, 1'b0, 24'h000801);
    scen(24'h999999, 24'h000001, 1'b0, 1'b0, 1'b0, 24'h000000);
    chk({31'h0, co_seen}, 32'h1);
    scen(24'h003674, 24'h002736, 1'b1, 1'b1, 1'b0, 24'h000938);
    chk({31'h0, list_seen}, 32'h1);
    wb(8'h00, 1'b0, 32'h0);
    chk(q, 32'h00000002); // loop bit kept for end-around
    wb(8'h04, 1'b0, 32'h0);
    chk(q, 32'h00002900); // idle at point nine with subtract held
    scen(24'h036748, 24'h027360, 1'b1, 1'b0, 1'b1, 24'h009388);
    scen(24'h000123, 24'h000000, 1'b1, 1'b1, 1'b0, 24'h000123);
    scen(24'h000005, 24'h999999, 1'b1, 1'b1, 1'b0, 24'h000005);
    results;
  end
endmodule
